// ### i2c_clk_pkg.sv
// Constants for the transfer clock selection and pin setup block
`default_nettype none
package i2c_clk_pkg;
  // Register addresses on the internal special-register bus
  localparam logic [15:0] PORT6_DIR_ADDR       = 16'hff26;
  localparam logic [15:0] FUNC_EXP_ADDR        = 16'hffa9;
  localparam logic [15:0] CLK_SEL_ADDR         = 16'hffa8;
  localparam logic [15:0] SERIAL_CTRL_ADDR     = 16'hffa6;
  // Reset values
  localparam logic [7:0]  PORT6_DIR_RESET      = 8'hff;
  localparam logic [7:0]  FUNC_EXP_RESET       = 8'h00;
  localparam logic [7:0]  CLK_SEL_RESET        = 8'h00;
  localparam logic [7:0]  SERIAL_CTRL_RESET    = 8'h00;
  // Field positions
  localparam int          CLK_EXT_BIT          = 0;
  localparam int          SPEED_MODE_BIT       = 3;
  localparam int          DIV_HI_BIT           = 1;
  localparam int          DIV_LO_BIT           = 0;
  localparam int          IF_ENABLE_BIT        = 7;
  localparam int          CLK_PIN_BIT          = 0;
  localparam int          DATA_PIN_BIT         = 1;
  // Fixed bit masks
  localparam logic [7:0]  FUNC_EXP_WMASK       = 8'h01;
  localparam logic [7:0]  PORT6_DIR_WMASK      = 8'h03;
  localparam logic [7:0]  CLK_SEL_WMASK        = 8'h0f;
  // Divide factors m, in selection-clock cycles
  localparam logic [6:0]  M_NORMAL_FAST        = 7'd44;
  localparam logic [6:0]  M_NORMAL_SLOW        = 7'd86;
  localparam logic [6:0]  M_HIGH_SPEED         = 7'd24;
  localparam logic [6:0]  M_HIGH_SPEED_EXT     = 7'd12;
  // Prescale of the peripheral clock to the selection clock
  localparam logic [1:0]  PRESCALE_DIV2        = 2'd2;
  localparam logic [1:0]  PRESCALE_DIV4        = 2'd0;
endpackage
`default_nettype wire

// ### clk_cfg_if.sv
// Interface carrying the decoded transfer clock setting to the generator
`default_nettype none
interface clk_cfg_if;
  logic       run;       // Interface enabled and code legal
  logic       div4;      // Selection clock is peripheral/4 instead of /2
  logic [6:0] m_cycles;  // SCL period in selection-clock cycles
  logic       scl_tick;  // Output toggle strobe, one cycle
  modport ctrl (output run, output div4, output m_cycles, input scl_tick);
  modport gen  (input run, input div4, input m_cycles, output scl_tick);
endinterface
`default_nettype wire

// ### scl_rate_gen.sv
// Selection clock prescaler and SCL half-period tick generator
`default_nettype none
module scl_rate_gen (
  // Clock and reset
  input  wire logic core_clk_in,
  input  wire logic reset_n_in,
  // Configuration
  clk_cfg_if.gen    cfg
);
  import i2c_clk_pkg::*;

  logic [1:0] pre_reg;
  logic [6:0] cnt_reg;
  logic       fw_tick;

  // Selection clock enable: peripheral/2 or peripheral/4
  assign fw_tick = cfg.div4 ? (pre_reg == 2'd3) : pre_reg[0];

  // Prescaler, cleared while stopped
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in || !cfg.run) begin
      pre_reg <= 2'd0;
    end else begin
      pre_reg <= pre_reg + 2'd1;
    end
  end

  // Half-period counter: m/2 selection-clock cycles per SCL phase
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in || !cfg.run) begin
      cnt_reg      <= 7'd0;
      cfg.scl_tick <= 1'b0;
    end else begin
      cfg.scl_tick <= 1'b0;
      if (fw_tick) begin
        if (cnt_reg >= (cfg.m_cycles >> 1) - 7'd1) begin
          cnt_reg      <= 7'd0;
          cfg.scl_tick <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg + 7'd1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### i2c_transfer_clock_select.sv
// Transfer clock selection registers, port 6 direction and I2C pin control
`default_nettype none
// Operation
// - Reset clears the function expansion register, so clock extend is zero.
// - Selection code is clock extend plus speed mode and two divider bits.
// - Normal mode: 00 gives /2 m44, 01 /2 m86, 10 /4 m86.
// - High speed: m24 or m12 by extend; hi bit 0 /2, 10 /4.
// - Disabled interface drives clock and data pins low in output mode.
// - Reset sets the port 6 direction register to all ones.
// - Direction bit 0 enables the output buffer, 1 selects input.
// - Direction is per bit; bits 1 and 0 steer data and clock pins.
// - While disabled the interface is stopped and its running flag held cleared.
module i2c_transfer_clock_select (
  // Clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        reset_n_in,
  // Special-register bus
  input  wire logic [15:0] reg_addr_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  input  wire logic [7:0]  reg_wdata_in,
  output var  logic [7:0]  reg_rdata_out,
  // Port output latches for pins 0 and 1
  input  wire logic [1:0]  port6_latch_in,
  // Bus clock pin (open drain)
  input  wire logic        bus_clock_pin_in,
  output var  logic        bus_clock_pin_out,
  output var  logic        bus_clock_pin_oe_n_out,
  // Bus data pin (open drain)
  input  wire logic        bus_data_pin_in,
  output var  logic        bus_data_pin_out,
  output var  logic        bus_data_pin_oe_n_out,
  // Status
  output var  logic        clock_legal_out,
  output var  logic        scl_running_out
);
  import i2c_clk_pkg::*;

  logic [7:0] function_expansion_reg;
  logic [7:0] transfer_clock_select_reg;
  logic [7:0] serial_control_reg;
  logic [7:0] port6_direction_reg;
  logic       scl_level_reg;
  logic       legal;
  logic       div4;
  logic [6:0] m_cycles;
  logic       interface_enable;
  logic [7:0] rdata_next;

  clk_cfg_if cfg_bus ();

  // Address match helper used by every register
  function automatic logic hit(input logic [15:0] a, input logic [15:0] r);
    return a == r;
  endfunction

  assign interface_enable = serial_control_reg[IF_ENABLE_BIT];

  // Function expansion register, only bit 0 stored
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      function_expansion_reg <= FUNC_EXP_RESET;
    end else if (reg_wr_in && hit(reg_addr_in, FUNC_EXP_ADDR)) begin
      function_expansion_reg <= reg_wdata_in & FUNC_EXP_WMASK;
    end
  end

  // Clock selection register, low four bits writable
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      transfer_clock_select_reg <= CLK_SEL_RESET;
    end else if (reg_wr_in && hit(reg_addr_in, CLK_SEL_ADDR)) begin
      transfer_clock_select_reg <= reg_wdata_in & CLK_SEL_WMASK;
    end
  end

  // Serial control register holding the interface enable
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      serial_control_reg <= SERIAL_CTRL_RESET;
    end else if (reg_wr_in && hit(reg_addr_in, SERIAL_CTRL_ADDR)) begin
      serial_control_reg <= reg_wdata_in;
    end
  end

  // Port 6 direction register, upper bits forced to one
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      port6_direction_reg <= PORT6_DIR_RESET;
    end else if (reg_wr_in && hit(reg_addr_in, PORT6_DIR_ADDR)) begin
      port6_direction_reg <= reg_wdata_in | ~PORT6_DIR_WMASK;
    end
  end

  // Decode of the four selection bits into prescale and divide factor
  always_comb begin
    legal    = 1'b1;
    div4     = 1'b0;
    m_cycles = M_NORMAL_FAST;
    unique case ({function_expansion_reg[CLK_EXT_BIT],
                  transfer_clock_select_reg[SPEED_MODE_BIT],
                  transfer_clock_select_reg[DIV_HI_BIT],
                  transfer_clock_select_reg[DIV_LO_BIT]})
      4'b0000: m_cycles = M_NORMAL_FAST;
      4'b0001: m_cycles = M_NORMAL_SLOW;
      4'b0010: begin
        div4     = 1'b1;
        m_cycles = M_NORMAL_SLOW;
      end
      4'b0100, 4'b0101: m_cycles = M_HIGH_SPEED;
      4'b0110: begin
        div4     = 1'b1;
        m_cycles = M_HIGH_SPEED;
      end
      4'b1100, 4'b1101: m_cycles = M_HIGH_SPEED_EXT;
      4'b1110: begin
        div4     = 1'b1;
        m_cycles = M_HIGH_SPEED_EXT;
      end
      default: legal = 1'b0;
    endcase
  end

  // Generator runs only while enabled with a legal code
  assign cfg_bus.run      = interface_enable && legal;
  assign cfg_bus.div4     = div4;
  assign cfg_bus.m_cycles = m_cycles;

  scl_rate_gen u_gen (
    .core_clk_in (core_clk_in),
    .reset_n_in  (reset_n_in),
    .cfg         (cfg_bus)
  );

  // Free-running SCL level, released high and held high while stopped
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in || !cfg_bus.run) begin
      scl_level_reg <= 1'b1;
    end else if (cfg_bus.scl_tick) begin
      scl_level_reg <= ~scl_level_reg;
    end
  end

  // Clock pin driver: level always low (open drain), enable low while driving
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      bus_clock_pin_out      <= 1'b0;
      bus_clock_pin_oe_n_out <= 1'b1;
    end else begin
      bus_clock_pin_out <= 1'b0;
      // Output buffer only when direction bit is 0
      if (port6_direction_reg[CLK_PIN_BIT]) begin
        bus_clock_pin_oe_n_out <= 1'b1;
      end else if (!interface_enable) begin
        bus_clock_pin_oe_n_out <= 1'b0;
      end else begin
        bus_clock_pin_oe_n_out <= scl_level_reg | port6_latch_in[CLK_PIN_BIT];
      end
    end
  end

  // Data pin driver; with no shifter here an enabled pin sits low unless its latch is set
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      bus_data_pin_out      <= 1'b0;
      bus_data_pin_oe_n_out <= 1'b1;
    end else begin
      bus_data_pin_out <= 1'b0;
      if (port6_direction_reg[DATA_PIN_BIT]) begin
        bus_data_pin_oe_n_out <= 1'b1;
      end else if (!interface_enable) begin
        bus_data_pin_oe_n_out <= 1'b0;
      end else begin
        bus_data_pin_oe_n_out <= port6_latch_in[DATA_PIN_BIT];
      end
    end
  end

  // Read multiplexer; selection register shows live pin levels in bits 5 and 4 while the interface is enabled
  always_comb begin
    rdata_next = 8'h00;
    if (hit(reg_addr_in, FUNC_EXP_ADDR)) begin
      rdata_next = function_expansion_reg;
    end else if (hit(reg_addr_in, CLK_SEL_ADDR)) begin
      rdata_next = transfer_clock_select_reg |
                   {2'b00, interface_enable & bus_clock_pin_in,
                    interface_enable & bus_data_pin_in, 4'h0};
    end else if (hit(reg_addr_in, SERIAL_CTRL_ADDR)) begin
      rdata_next = serial_control_reg;
    end else if (hit(reg_addr_in, PORT6_DIR_ADDR)) begin
      rdata_next = port6_direction_reg;
    end
  end

  // Registered read data, zero when no read is under way
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      reg_rdata_out <= 8'h00;
    end else begin
      reg_rdata_out <= reg_rd_in ? rdata_next : 8'h00;
    end
  end

  // Legal-code flag; all selection bits clear to a legal code, so it starts high
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      clock_legal_out <= 1'b1;
    end else begin
      clock_legal_out <= legal;
    end
  end

  // Running flag follows the generator enable
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      scl_running_out <= 1'b0;
    end else begin
      scl_running_out <= cfg_bus.run;
    end
  end
endmodule
`default_nettype wire

// ### i2c_clk_peer.sv
// Bus peer: pull-up resolution of the open-drain clock and data lines
`default_nettype none
module i2c_clk_peer (
  // Design side drive
  input  wire logic clk_oe_n_in,
  input  wire logic clk_drv_in,
  input  wire logic dat_oe_n_in,
  input  wire logic dat_drv_in,
  // Resolved line levels
  output var  logic scl_out,
  output var  logic sda_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // A released line is pulled up, never left at its last value
  always_comb scl_out = clk_oe_n_in ? 1'b1 : clk_drv_in;
  always_comb sda_out = dat_oe_n_in ? 1'b1 : dat_drv_in;
endmodule
`default_nettype wire

// ### i2c_transfer_clock_select_sva.sv
// Port assertions for the transfer clock select block
`default_nettype none
module i2c_transfer_clock_select_sva
  import i2c_clk_pkg::*;
(
  input wire logic        core_clk_in,
  input wire logic        reset_n_in,
  input wire logic [15:0] reg_addr_in,
  input wire logic        reg_wr_in,
  input wire logic        reg_rd_in,
  input wire logic [7:0]  reg_wdata_in,
  input wire logic [7:0]  reg_rdata_out,
  input wire logic [1:0]  port6_latch_in,
  input wire logic        bus_clock_pin_oe_n_out,
  input wire logic        bus_data_pin_oe_n_out,
  input wire logic        bus_clock_pin_out,
  input wire logic        bus_data_pin_out,
  input wire logic        clock_legal_out,
  input wire logic        scl_running_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] dir_reg;
  logic [3:0] sel_reg;
  logic       ext_reg;
  logic       en_reg;
  logic       legal;
  // Shadow of the control bits as written
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      dir_reg <= 2'h3;
      sel_reg <= 4'h0;
      ext_reg <= 1'b0;
      en_reg  <= 1'b0;
    end else if (reg_wr_in) begin
      if (reg_addr_in == PORT6_DIR_ADDR) dir_reg <= reg_wdata_in[1:0];
      if (reg_addr_in == CLK_SEL_ADDR) sel_reg <= reg_wdata_in[3:0];
      if (reg_addr_in == FUNC_EXP_ADDR) ext_reg <= reg_wdata_in[0];
      if (reg_addr_in == SERIAL_CTRL_ADDR) en_reg <= reg_wdata_in[7];
    end
  end
  assign legal = (sel_reg[1:0] != 2'h3) && !(ext_reg && !sel_reg[3]);
  default clocking @(posedge core_clk_in); endclocking
  property p_rst;
    $rose(reset_n_in) |-> bus_clock_pin_oe_n_out && bus_data_pin_oe_n_out;
  endproperty
  a_rst: assert property (p_rst) else $error("pins not released after reset");
  default disable iff (!reset_n_in);
  property p_dir_rd;
    reg_rd_in && reg_addr_in == PORT6_DIR_ADDR |=> reg_rdata_out == {6'h3f, $past(dir_reg)};
  endproperty
  a_dir_rd: assert property (p_dir_rd) else $error("direction readback");
  property p_ext_rd;
    reg_rd_in && reg_addr_in == FUNC_EXP_ADDR |=> reg_rdata_out == {7'h0, $past(ext_reg)};
  endproperty
  a_ext_rd: assert property (p_ext_rd) else $error("expansion readback");
  property p_clk_in; dir_reg[0] |=> bus_clock_pin_oe_n_out; endproperty
  a_clk_in: assert property (p_clk_in) else $error("clock pin driven in input mode");
  property p_dat_in; dir_reg[1] |=> bus_data_pin_oe_n_out; endproperty
  a_dat_in: assert property (p_dat_in) else $error("data pin driven in input mode");
  property p_off_low; !en_reg && !dir_reg[0] |=> !bus_clock_pin_oe_n_out; endproperty
  a_off_low: assert property (p_off_low) else $error("disabled clock pin not low");
  property p_latch;
    en_reg && !dir_reg[1] |=> bus_data_pin_oe_n_out == $past(port6_latch_in[1]);
  endproperty
  a_latch: assert property (p_latch) else $error("data pin ignores latch");
  property p_od_low; !bus_clock_pin_out && !bus_data_pin_out; endproperty
  a_od_low: assert property (p_od_low) else $error("open-drain output driven high");
  property p_legal; $stable(legal) |-> clock_legal_out == legal; endproperty
  a_legal: assert property (p_legal) else $error("legal flag wrong");
  property p_run; $stable(legal && en_reg) |-> scl_running_out == (legal && en_reg); endproperty
  a_run: assert property (p_run) else $error("running flag wrong");
  c_run: cover property (scl_running_out);
  c_low: cover property (!en_reg && !bus_clock_pin_oe_n_out);
  c_bad: cover property (!clock_legal_out);
endmodule
`default_nettype wire

// ### i2c_transfer_clock_select_tb.sv
// Testbench for the transfer clock select block
`default_nettype none
module i2c_transfer_clock_select_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import i2c_clk_pkg::*;
  logic        clk, rst_n, wr, rd, scl, sda, cko, ckoe, dao, daoe, legal, run;
  logic [15:0] addr;
  logic [7:0]  wdata, rdata;
  logic [1:0]  latch;
  int          fails, total_checks, n;
  logic [4:0]  code [7] = '{5'h00, 5'h01, 5'h02, 5'h0c, 5'h0e, 5'h1c, 5'h1e};
  int          per [7] = '{88, 172, 344, 48, 96, 24, 48};
  i2c_transfer_clock_select i2c_transfer_clock_select_i (.core_clk_in(clk), .reset_n_in(rst_n),
    .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata),
    .reg_rdata_out(rdata), .port6_latch_in(latch), .bus_clock_pin_in(scl),
    .bus_clock_pin_out(cko), .bus_clock_pin_oe_n_out(ckoe), .bus_data_pin_in(sda),
    .bus_data_pin_out(dao), .bus_data_pin_oe_n_out(daoe), .clock_legal_out(legal),
    .scl_running_out(run));
  i2c_clk_peer i2c_clk_peer_i (.clk_oe_n_in(ckoe), .clk_drv_in(cko), .dat_oe_n_in(daoe),
    .dat_drv_in(dao), .scl_out(scl), .sda_out(sda));
  // Compare tasks
  task automatic chkv(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t bit %b expected %b", $time, got, exp);
    end
  endtask
  // Register bus cycles
  task automatic wreg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chkv({8'h00, rdata}, {8'h00, e});
  endtask
  // Wait, bounded, until the clock line shows level v
  task automatic wl(input logic v);
    while (scl !== v && n < 3000) begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (50000) @(posedge clk);
    fails++;
    end_of_test();
  end
  initial begin
    {rst_n, wr, rd, addr, wdata, latch} = '0;
    fails = 0;
    total_checks = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    #1 chk1(ckoe & daoe, 1'b1);
    rreg(PORT6_DIR_ADDR, 8'hff);
    rreg(FUNC_EXP_ADDR, 8'h00);
    rreg(16'h0000, 8'h00);
    wreg(FUNC_EXP_ADDR, 8'hff);
    rreg(FUNC_EXP_ADDR, 8'h01);
    wreg(PORT6_DIR_ADDR, 8'h00);
    rreg(PORT6_DIR_ADDR, 8'hfc);
    chk1(ckoe | daoe, 1'b0);
    wreg(PORT6_DIR_ADDR, 8'h02);
    repeat (2) @(posedge clk);
    #1 chkv({ckoe, daoe}, 16'h0001);
    // Every selection code, interface disabled; pin level bits must read clear
    for (int c = 0; c < 16; c++) begin
      wreg(FUNC_EXP_ADDR, {7'h0, c[3]});
      wreg(CLK_SEL_ADDR, {4'h0, c[2], 1'b0, c[1:0]});
      repeat (2) @(posedge clk);
      #1 chk1(legal, !(c[1:0] == 2'h3 || (c[3] && !c[2])));
      rreg(CLK_SEL_ADDR, {4'h0, c[2], 1'b0, c[1:0]});
    end
    wreg(PORT6_DIR_ADDR, 8'h00);
    // Clock period for seven of the legal codes, in core cycles, timed from a steady rising edge
    for (int k = 0; k < 7; k++) begin
      wreg(FUNC_EXP_ADDR, {7'h0, code[k][4]});
      wreg(CLK_SEL_ADDR, {4'h0, code[k][3:0]});
      wreg(SERIAL_CTRL_ADDR, 8'h80);
      n = 0;
      repeat (2) begin
        wl(1'b0);
        wl(1'b1);
      end
      n = 0;
      wl(1'b0);
      wl(1'b1);
      chkv(16'(n), 16'(per[k]));
      chk1(run, 1'b1);
      chk1(sda, 1'b0);
      latch <= 2'b10;
      repeat (2) @(posedge clk);
      #1 chk1(sda, 1'b1);
      @(posedge clk);
      latch <= 2'b00;
      wreg(SERIAL_CTRL_ADDR, 8'h00);
      repeat (2) @(posedge clk);
      #1 chk1(run, 1'b0);
    end
    // Prohibited code while enabled: generator stays stopped and the clock is released
    wreg(CLK_SEL_ADDR, 8'h03);
    wreg(SERIAL_CTRL_ADDR, 8'h80);
    repeat (2) @(posedge clk);
    #1 chk1(run, 1'b0);
    chk1(scl, 1'b1);
    chk1(legal, 1'b0);
    // Reset while enabled on the prohibited code restores both registers and releases the pins
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    #1 chk1(ckoe & daoe, 1'b1);
    rreg(PORT6_DIR_ADDR, 8'hff);
    rreg(FUNC_EXP_ADDR, 8'h00);
    end_of_test();
  end
endmodule
bind i2c_transfer_clock_select i2c_transfer_clock_select_sva i2c_transfer_clock_select_sva_i (
  .core_clk_in            (core_clk_in),
  .reset_n_in             (reset_n_in),
  .reg_addr_in            (reg_addr_in),
  .reg_wr_in              (reg_wr_in),
  .reg_rd_in              (reg_rd_in),
  .reg_wdata_in           (reg_wdata_in),
  .reg_rdata_out          (reg_rdata_out),
  .port6_latch_in         (port6_latch_in),
  .bus_clock_pin_oe_n_out (bus_clock_pin_oe_n_out),
  .bus_data_pin_oe_n_out  (bus_data_pin_oe_n_out),
  .bus_clock_pin_out      (bus_clock_pin_out),
  .bus_data_pin_out       (bus_data_pin_out),
  .clock_legal_out        (clock_legal_out),
  .scl_running_out        (scl_running_out)
);
`default_nettype wire
